// ==== rtl/tho_pkg.sv ====
package tho_pkg;
  // register indices; byte address is four times the index
  localparam logic [7:0] IDX_MISC = 8'h0d;
  localparam logic [7:0] IDX_FIRST = 8'h0e;
  localparam logic [7:0] IDX_SECOND = 8'h0f;
  localparam logic [7:0] IDX_THIRD = 8'h11;
  localparam logic [7:0] IDX_MODE = 8'h13;
  localparam logic [7:0] IDX_CTRL = 8'h20;
  localparam logic [7:0] IDX_STAT = 8'h21;
  // storage slots
  localparam int NREG = 5;
  localparam logic [2:0] SL_MISC = 3'h0;
  localparam logic [2:0] SL_FIRST = 3'h1;
  localparam logic [2:0] SL_SECOND = 3'h2;
  localparam logic [2:0] SL_THIRD = 3'h3;
  localparam logic [2:0] SL_MODE = 3'h4;
  localparam logic [2:0] SL_NONE = 3'h7;
  // reset values
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [7:0] CTRL_RST = 8'h02;
  // control fields
  localparam int CTRL_RELOAD_BIT = 0;
  localparam int CTRL_REV2_BIT = 1;
  // field positions
  localparam int PERS_TOP_BIT = 4;
  localparam int PERS_LOW_MSB = 2;
  localparam int SYNC_BIT = 3;
  localparam int ID_MSB = 2;
  localparam int LA_MSB = 3;
  localparam int MODE_MSB = 2;
  // switch polarity: ones where stored bit equals switch on (flat {mode,third,second,first,misc})
  localparam logic [39:0] SW_ON_MASK = 40'h00_00_07_00_00;
  // personality codes
  localparam logic [3:0] PCODE_STD = 4'hd;
  localparam logic [3:0] PCODE_ALT = 4'he;
  localparam logic [3:0] PCODE_SYNC = 4'hf;
  // block mode codes and lengths
  localparam logic [2:0] BM_VAR1 = 3'h1;
  localparam logic [2:0] BM_256 = 3'h2;
  localparam logic [2:0] BM_512 = 3'h3;
  localparam logic [2:0] BM_1K = 3'h4;
  localparam logic [2:0] BM_4K = 3'h5;
  localparam logic [2:0] BM_16K = 3'h6;
  localparam logic [2:0] BM_32K = 3'h7;
  localparam logic [15:0] LEN_256 = 16'h0100;
  localparam logic [15:0] LEN_512 = 16'h0200;
  localparam logic [15:0] LEN_1K = 16'h0400;
  localparam logic [15:0] LEN_4K = 16'h1000;
  localparam logic [15:0] LEN_16K = 16'h4000;
  localparam logic [15:0] LEN_32K = 16'h8000;
  localparam logic [7:0] LA_ZERO_MARKS = 8'hff;
  // status word fields
  localparam int ST_ID_LSB = 0;
  localparam int ST_VALID_BIT = 3;
  localparam int ST_PERS_LSB = 4;
  localparam int ST_SYNC_BIT = 8;
  localparam int ST_FIXED_BIT = 9;
  localparam int ST_LOAD_BIT = 10;
  localparam int ST_MARKS_LSB = 16;

  typedef enum logic [3:0] {
    PERS_NONE = 4'b0001,
    PERS_STD = 4'b0010,
    PERS_ALT = 4'b0100,
    PERS_SYNC = 4'b1000
  } tho_pers_t;

  typedef enum logic [2:0] {
    LD_LOAD = 3'b001,
    LD_APPLY = 3'b010,
    LD_RUN = 3'b100
  } tho_ld_t;
endpackage

// ==== rtl/tho_decode.sv ====
`timescale 1ns/1ns
`default_nettype none
module tho_decode #(
  parameter logic [15:0] REV1_FIXED_CODES = 16'h2000
) (
  // option bytes
  input wire logic [7:0] first_b,
  input wire logic [7:0] second_b,
  input wire logic [7:0] third_b,
  input wire logic [7:0] mode_b,
  input wire logic rev2,
  // decoded
  output var tho_pkg::tho_pers_t pers,
  output logic pers_valid,
  output logic sync_en,
  output logic fixed,
  output logic [15:0] block_bytes,
  output logic [7:0] marks,
  output logic [2:0] host_id
);
  logic [3:0] code;
  logic apply_ok;
  logic [2:0] bm;

  always_comb begin
    code = {second_b[tho_pkg::PERS_TOP_BIT], first_b[tho_pkg::PERS_LOW_MSB:0]};
    pers = tho_pkg::PERS_NONE;
    pers_valid = 1'b0;
    if (code == tho_pkg::PCODE_STD) begin
      pers = tho_pkg::PERS_STD;
      pers_valid = 1'b1;
    end else if (code == tho_pkg::PCODE_ALT) begin
      pers = tho_pkg::PERS_ALT;
      pers_valid = 1'b1;
    end else if (code == tho_pkg::PCODE_SYNC) begin
      pers = tho_pkg::PERS_SYNC;
      pers_valid = 1'b1;
    end
    // permission is active low and only meaningful for the last personality
    sync_en = (pers == tho_pkg::PERS_SYNC) && !second_b[tho_pkg::SYNC_BIT];
    // earlier revision honours the field only for listed codes
    apply_ok = rev2 || REV1_FIXED_CODES[code];
    bm = apply_ok ? mode_b[tho_pkg::MODE_MSB:0] : 3'h0;
    fixed = 1'b1;
    case (bm)
      tho_pkg::BM_256: block_bytes = tho_pkg::LEN_256;
      tho_pkg::BM_512: block_bytes = tho_pkg::LEN_512;
      tho_pkg::BM_1K: block_bytes = tho_pkg::LEN_1K;
      tho_pkg::BM_4K: block_bytes = tho_pkg::LEN_4K;
      tho_pkg::BM_16K: block_bytes = tho_pkg::LEN_16K;
      tho_pkg::BM_32K: block_bytes = tho_pkg::LEN_32K;
      default: begin
        block_bytes = 16'h0000;
        fixed = 1'b0;
      end
    endcase
    if (third_b[tho_pkg::LA_MSB:0] == 4'h0) begin
      marks = tho_pkg::LA_ZERO_MARKS;
    end else begin
      marks = {4'h0, third_b[tho_pkg::LA_MSB:0]};
    end
    host_id = second_b[tho_pkg::ID_MSB:0];
  end
endmodule
`default_nettype wire

// ==== rtl/tho_bank.sv ====
// Operation
// - stored one means switch off, except ID
// - single-bit option acts only when one
// - personality from byte 15 and byte 14
// - power-up block mode from byte 19 bits
// - last personality: bit clear enables sync
// - first revision applies mode for some codes
// - later revisions apply mode for every code
// - look-ahead stop count, zero means 255
//
// Design decision made here: the AHB-Lite interface to the registers.
`timescale 1ns/1ns
`default_nettype none
module tho_bank #(
  parameter logic [15:0] REV1_FIXED_CODES = 16'h2000
) (
  // clock, reset, enable
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic ce,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // on-board switches, one means on
  input wire logic [7:0] sw_misc,
  input wire logic [7:0] sw_first,
  input wire logic [7:0] sw_second,
  input wire logic [7:0] sw_third,
  input wire logic [7:0] sw_mode,
  // decoded personality
  output logic [2:0] host_id,
  output logic [3:0] personality,
  output logic personality_valid,
  output logic sync_xfer_enable,
  output logic [13:0] option_flags,
  output logic [7:0] lookahead_marks,
  // power-up block mode
  output logic fixed_mode,
  output logic [15:0] block_bytes,
  output logic loading
);
  logic [7:0] mem [0:tho_pkg::NREG-1];
  logic [7:0] ctrl;
  tho_pkg::tho_ld_t ld_state;
  logic [39:0] sw_flat;
  logic [39:0] sw_stored;
  // address phase capture
  logic dp_wr;
  logic [2:0] dp_slot;
  logic dp_ctrl;
  logic ap_take;
  logic [2:0] ap_slot;
  logic ap_ctrl;
  logic ap_stat;
  logic [31:0] next_rdata;
  logic [7:0] cur_byte;
  logic reload_req;
  // decoder results
  tho_pkg::tho_pers_t d_pers;
  logic d_valid;
  logic d_sync;
  logic d_fixed;
  logic [15:0] d_bytes;
  logic [7:0] d_marks;
  logic [2:0] d_id;
  logic [31:0] status;

  assign sw_flat = {sw_mode, sw_third, sw_second, sw_first, sw_misc};

  // switch polarity per bit
  genvar gi;
  generate
    for (gi = 0; gi < 40; gi = gi + 1) begin : g_sw
      assign sw_stored[gi] = tho_pkg::SW_ON_MASK[gi] ? sw_flat[gi] : !sw_flat[gi];
    end
  endgenerate

  assign ap_take = hsel && hready && htrans[1];

  // address decode
  always_comb begin
    ap_slot = tho_pkg::SL_NONE;
    ap_ctrl = 1'b0;
    ap_stat = 1'b0;
    if (haddr[31:10] != 22'h0 || haddr[1:0] != 2'h0) begin
      ap_slot = tho_pkg::SL_NONE;
    end else if (haddr[9:2] == tho_pkg::IDX_MISC) begin
      ap_slot = tho_pkg::SL_MISC;
    end else if (haddr[9:2] == tho_pkg::IDX_FIRST) begin
      ap_slot = tho_pkg::SL_FIRST;
    end else if (haddr[9:2] == tho_pkg::IDX_SECOND) begin
      ap_slot = tho_pkg::SL_SECOND;
    end else if (haddr[9:2] == tho_pkg::IDX_THIRD) begin
      ap_slot = tho_pkg::SL_THIRD;
    end else if (haddr[9:2] == tho_pkg::IDX_MODE) begin
      ap_slot = tho_pkg::SL_MODE;
    end else if (haddr[9:2] == tho_pkg::IDX_CTRL) begin
      ap_ctrl = 1'b1;
    end else if (haddr[9:2] == tho_pkg::IDX_STAT) begin
      ap_stat = 1'b1;
    end
  end

  assign status = {8'h00, d_marks, 5'h00, (ld_state != tho_pkg::LD_RUN), d_fixed, d_sync,
                   d_pers, d_valid, d_id};

  // read data is prepared in the address phase; a write still in its data phase is forwarded
  always_comb begin
    cur_byte = 8'h00;
    if (ap_slot != tho_pkg::SL_NONE) begin
      cur_byte = mem[ap_slot];
      if (dp_wr && dp_slot == ap_slot) begin
        cur_byte = hwdata[7:0];
      end
    end
    next_rdata = 32'h0000_0000;
    if (ap_slot != tho_pkg::SL_NONE) begin
      next_rdata = {24'h00_0000, cur_byte};
    end else if (ap_ctrl) begin
      next_rdata = {24'h00_0000, 6'h00, ctrl[tho_pkg::CTRL_REV2_BIT], 1'b0};
      if (dp_wr && dp_ctrl) begin
        next_rdata = {24'h00_0000, 6'h00, hwdata[tho_pkg::CTRL_REV2_BIT], 1'b0};
      end
    end else if (ap_stat) begin
      next_rdata = status;
    end
  end

  // data phase tracking
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dp_wr <= 1'b0;
      dp_slot <= tho_pkg::SL_NONE;
      dp_ctrl <= 1'b0;
    end else if (ce) begin
      if (hready) begin
        dp_wr <= ap_take && hwrite;
        dp_slot <= ap_slot;
        dp_ctrl <= ap_ctrl;
      end
    end
  end

  // bus answer: no wait states, always okay
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else if (ce) begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end

  // read data stands until the next read address phase is taken
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else if (ce) begin
      if (ap_take && !hwrite) begin
        hrdata <= next_rdata;
      end
    end
  end

  assign reload_req = dp_wr && dp_ctrl && hwdata[tho_pkg::CTRL_RELOAD_BIT];

  // control register; reload bit is a strobe and reads zero
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl <= tho_pkg::CTRL_RST;
    end else if (ce) begin
      if (dp_wr && dp_ctrl) begin
        ctrl <= {6'h00, hwdata[tho_pkg::CTRL_REV2_BIT], 1'b0};
      end
    end
  end

  // load sequencer: switches are caught after reset release or on request
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ld_state <= tho_pkg::LD_LOAD;
    end else if (ce) begin
      case (ld_state)
        tho_pkg::LD_LOAD: ld_state <= tho_pkg::LD_APPLY;
        tho_pkg::LD_APPLY: ld_state <= tho_pkg::LD_RUN;
        tho_pkg::LD_RUN: begin
          if (reload_req) begin
            ld_state <= tho_pkg::LD_LOAD;
          end
        end
        default: ld_state <= tho_pkg::LD_LOAD;
      endcase
    end
  end

  // option store; the switch load overrides a software write in the same cycle
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      for (int i = 0; i < tho_pkg::NREG; i++) begin
        mem[i] <= tho_pkg::RST_BYTE;
      end
    end else if (ce) begin
      if (ld_state == tho_pkg::LD_LOAD) begin
        for (int i = 0; i < tho_pkg::NREG; i++) begin
          mem[i] <= sw_stored[8*i +: 8];
        end
      end else if (dp_wr && dp_slot != tho_pkg::SL_NONE) begin
        mem[dp_slot] <= hwdata[7:0];
      end
    end
  end

  tho_decode #(
    .REV1_FIXED_CODES(REV1_FIXED_CODES)
  ) u_dec (
    .first_b(mem[tho_pkg::SL_FIRST]),
    .second_b(mem[tho_pkg::SL_SECOND]),
    .third_b(mem[tho_pkg::SL_THIRD]),
    .mode_b(mem[tho_pkg::SL_MODE]),
    .rev2(ctrl[tho_pkg::CTRL_REV2_BIT]),
    .pers(d_pers),
    .pers_valid(d_valid),
    .sync_en(d_sync),
    .fixed(d_fixed),
    .block_bytes(d_bytes),
    .marks(d_marks),
    .host_id(d_id)
  );

  // live option outputs follow the store one cycle later
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      host_id <= 3'h0;
    end else if (ce) begin
      host_id <= d_id;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      personality <= tho_pkg::PERS_NONE;
      personality_valid <= 1'b0;
    end else if (ce) begin
      personality <= d_pers;
      personality_valid <= d_valid;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sync_xfer_enable <= 1'b0;
    end else if (ce) begin
      sync_xfer_enable <= d_sync;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      lookahead_marks <= tho_pkg::LA_ZERO_MARKS;
    end else if (ce) begin
      lookahead_marks <= d_marks;
    end
  end

  // each flag is active only while its stored bit is one
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      option_flags <= 14'h0000;
    end else if (ce) begin
      option_flags <= {mem[tho_pkg::SL_THIRD][7:5], mem[tho_pkg::SL_SECOND][7:5],
                       mem[tho_pkg::SL_SECOND][3], mem[tho_pkg::SL_FIRST][7:3],
                       mem[tho_pkg::SL_MISC][6], mem[tho_pkg::SL_MISC][4]};
    end
  end

  // block mode is taken only at the apply step, as at power-up
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      fixed_mode <= 1'b0;
      block_bytes <= 16'h0000;
    end else if (ce) begin
      if (ld_state == tho_pkg::LD_APPLY) begin
        fixed_mode <= d_fixed;
        block_bytes <= d_bytes;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      loading <= 1'b1;
    end else if (ce) begin
      loading <= (ld_state != tho_pkg::LD_RUN) || reload_req;
    end
  end
endmodule
`default_nettype wire

// ==== verif/tho_switch_panel.sv ====
`timescale 1ns/1ns
`default_nettype none
module tho_switch_panel (
  // switch positions {mode,third,second,first,misc}, one means on
  input wire logic [39:0] pos,
  // switch levels
  output logic [7:0] sw_misc,
  output logic [7:0] sw_first,
  output logic [7:0] sw_second,
  output logic [7:0] sw_third,
  output logic [7:0] sw_mode
);
  assign {sw_mode, sw_third, sw_second, sw_first, sw_misc} = pos;
endmodule
`default_nettype wire

// ==== verif/tho_bank_sva.sv ====
`timescale 1ns/1ns
`default_nettype none
module tho_bank_sva (
  // watched ports
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic [3:0] personality,
  input wire logic personality_valid,
  input wire logic sync_xfer_enable,
  input wire logic [7:0] lookahead_marks,
  input wire logic fixed_mode,
  input wire logic [15:0] block_bytes,
  input wire logic loading
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  a_ready_high: assert property (hreadyout) else $error("hreadyout low");
  a_resp_okay: assert property (!hresp) else $error("hresp not okay");
  a_pers_onehot: assert property ($onehot(personality))
    else $error("personality not one-hot");
  a_valid_match: assert property (personality_valid == (personality != 4'h1))
    else $error("valid wrong");
  a_sync_last: assert property (sync_xfer_enable |-> personality == 4'h8)
    else $error("sync wrong");
  a_marks_range: assert property (lookahead_marks inside {[8'h01:8'h0f], 8'hff})
    else $error("marks range");
  a_fixed_len: assert property (fixed_mode == (block_bytes != 16'h0000))
    else $error("fixed wrong");
  a_len_set: assert property (fixed_mode |-> block_bytes inside {16'h0100, 16'h0200, 16'h0400, 16'h1000,
    16'h4000, 16'h8000}) else $error("length wrong");
  a_load_ends: assert property (loading |-> ##[1:8] !loading)
    else $error("load stuck");
  a_mode_hold: assert property (!loading && !$past(loading) |=> $stable(block_bytes))
    else $error("mode moved");
  c_sync: cover property (sync_xfer_enable);
  c_fixed_max: cover property (fixed_mode && block_bytes == 16'h8000);
  c_reload: cover property ($fell(loading));
endmodule
bind tho_bank tho_bank_sva i_sva (.hclk, .hresetn, .hreadyout, .hresp, .personality, .personality_valid,
  .sync_xfer_enable, .lookahead_marks, .fixed_mode, .block_bytes, .loading);
`default_nettype wire

// ==== verif/tho_bank_test.sv ====
`timescale 1ns/1ns
`default_nettype none
module tho_bank_test;
  localparam logic [15:0] FIX1 = 16'h6000;
  logic hclk = 0, hresetn = 0, ce = 0, hsel = 0, hwrite = 0, rev2 = 1;
  logic [31:0] haddr = 0, hwdata = 0, rdat, r;
  logic [1:0] htrans = 0;
  logic [2:0] hsize = 3'h2;
  logic [39:0] pos = 0;
  logic [7:0] st [0:4];
  logic [7:0] ix [0:4] = '{tho_pkg::IDX_MISC, tho_pkg::IDX_FIRST, tho_pkg::IDX_SECOND, tho_pkg::IDX_THIRD,
    tho_pkg::IDX_MODE};
  logic [15:0] lens [0:7] = '{16'h0, 16'h0, 16'h0100, 16'h0200, 16'h0400, 16'h1000, 16'h4000, 16'h8000};
  logic [15:0] blk;
  logic [3:0] pc;
  wire logic hready, hreadyout, hresp, personality_valid, sync_xfer_enable, fixed_mode, loading;
  wire logic [31:0] hrdata;
  wire logic [7:0] sw_misc, sw_first, sw_second, sw_third, sw_mode, lookahead_marks;
  wire logic [2:0] host_id;
  wire logic [3:0] personality;
  wire logic [13:0] option_flags;
  wire logic [15:0] block_bytes;
  integer seed = 11, n_fail = 0, checks = 0, i, c, m;
  initial begin
    forever #4 hclk = ~hclk;
  end
  assign hready = hreadyout;
  tho_switch_panel i_panel (.pos(pos), .sw_misc(sw_misc), .sw_first(sw_first), .sw_second(sw_second),
    .sw_third(sw_third), .sw_mode(sw_mode));
  tho_bank #(.REV1_FIXED_CODES(FIX1)) i_dut (.hclk(hclk), .hresetn(hresetn), .ce(ce), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .sw_misc(sw_misc), .sw_first(sw_first),
    .sw_second(sw_second), .sw_third(sw_third), .sw_mode(sw_mode), .host_id(host_id),
    .personality(personality), .personality_valid(personality_valid), .sync_xfer_enable(sync_xfer_enable),
    .option_flags(option_flags), .lookahead_marks(lookahead_marks), .fixed_mode(fixed_mode),
    .block_bytes(block_bytes), .loading(loading));
  task end_sim;
    if (n_fail == 0 && checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      n_fail++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  task bus(input logic w, input logic [31:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= a;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rdat = hrdata;
  endtask
  task settle;
    integer k;
    repeat (2) @(posedge hclk);
    for (k = 0; k < 20 && loading !== 1'b0; k++) @(posedge hclk);
    @(posedge hclk);
    #1;
  endtask
  function logic [31:0] ad(input logic [7:0] x);
    return {22'h0, x, 2'b00};
  endfunction
  function logic [3:0] pers_of(input logic [3:0] x);
    return x == 4'hd ? 4'h2 : x == 4'he ? 4'h4 : x == 4'hf ? 4'h8 : 4'h1;
  endfunction
  task check_all;
    logic [3:0] k;
    k = {st[2][4], st[1][2:0]};
    chk("personality", pers_of(k), personality);
    chk("valid", pers_of(k) != 4'h1, personality_valid);
    chk("sync", k == 4'hf && !st[2][3], sync_xfer_enable);
    chk("host_id", st[2][2:0], host_id);
    chk("marks", st[3][3:0] == 4'h0 ? 8'hff : {4'h0, st[3][3:0]}, lookahead_marks);
    chk("flags", {st[3][7:5], st[2][7:5], st[2][3], st[1][7:3], st[0][6], st[0][4]}, option_flags);
    chk("block", blk, block_bytes);
    chk("fixed", blk != 16'h0, fixed_mode);
  endtask
  initial begin
    for (i = 0; i < 5; i++) begin
      r = $random(seed);
      st[i] = r[7:0];
    end
    pos = ~{st[4], st[3], st[2], st[1], st[0]} ^ tho_pkg::SW_ON_MASK;
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    ce <= 1'b1;
    settle;
    blk = lens[st[4][2:0]];
    for (i = 0; i < 5; i++) begin
      bus(1'b0, ad(ix[i]), 32'h0);
      chk("byte", {24'h0, st[i]}, rdat);
    end
    check_all;
    for (c = 0; c < 16; c++) begin
      r = $random(seed);
      st[0] = r[31:24];
      st[1] = {r[7:3], c[2:0]};
      st[2] = {r[15:13], c[3], r[11:8]};
      st[3] = {r[23:20], c[3:0]};
      st[4] = r[18:11];
      for (i = 0; i < 5; i++) begin
        r = $random(seed);
        bus(1'b1, ad(ix[i]), {r[31:8], st[i]});
      end
      bus(1'b0, ad(ix[c % 5]), 32'h0);
      chk("readback", {24'h0, st[c % 5]}, rdat);
      settle;
      check_all;
    end
    for (m = 0; m < 16; m++) begin
      pc = 4'hc + m[1:0];
      st[1][2:0] = pc[2:0];
      st[2][4] = pc[3];
      st[4][2:0] = m[3:1];
      pos <= ~{st[4], st[3], st[2], st[1], st[0]} ^ tho_pkg::SW_ON_MASK;
      bus(1'b1, 32'h80, {30'h0, m[0], 1'b1});
      rev2 = m[0];
      bus(1'b0, 32'h80, 32'h0);
      chk("ctrl", {30'h0, rev2, 1'b0}, rdat);
      settle;
      blk = (rev2 || FIX1[pc]) ? lens[m[3:1]] : 16'h0;
      check_all;
      bus(1'b0, 32'h84, 32'h0);
      r = {8'h0, (st[3][3:0] == 4'h0 ? 8'hff : {4'h0, st[3][3:0]}), 6'h0, blk != 16'h0,
        pc == 4'hf && !st[2][3], pers_of(pc), pers_of(pc) != 4'h1, st[2][2:0]};
      chk("status", r, rdat);
    end
    bus(1'b1, 32'h40, 32'hff);
    bus(1'b0, 32'h40, 32'h0);
    chk("unmapped", 32'h0, rdat);
    bus(1'b0, 32'h39, 32'h0);
    chk("misaligned", 32'h0, rdat);
    ce <= 1'b0;
    bus(1'b1, ad(ix[1]), {24'h0, ~st[1]});
    ce <= 1'b1;
    bus(1'b0, ad(ix[1]), 32'h0);
    chk("frozen", {24'h0, st[1]}, rdat);
    end_sim;
  end
  initial begin
    #100000;
    n_fail++;
    end_sim;
  end
endmodule
`default_nettype wire
